/* logic/analog_output_defs.vh */
// Constants for the analog output code generator
`ifndef ANALOG_OUTPUT_DEFS_VH
`define ANALOG_OUTPUT_DEFS_VH

// Register byte offsets
`define AO_CTRL_OFF 12'h000
`define AO_STAT_OFF 12'h004
`define AO_MASK_OFF 12'h008
`define AO_CODE_OFF 12'h00C
`define AO_MODE_OFF 12'h010

// Control field positions
`define CTRL_MODE_LSB 0
`define CTRL_TSEL_BIT 3
`define CTRL_TPICK_BIT 4
`define CTRL_PRAW_BIT 5
`define CTRL_T1RAW_BIT 6
`define CTRL_T2RAW_BIT 7
`define CTRL_CLIPH_LSB 8
`define CTRL_CLIPL_LSB 11
`define CTRL_DIAG_BIT 14
`define CTRL_RESET_VAL 32'h0000_0000

// Output mode encodings
`define MODE_OFF 3'h0
`define MODE_RATIO 3'h4
`define MODE_ABS3 3'h5
`define MODE_ABS5 3'h6
`define MODE_LOOP 3'h7

// Reference select encodings
`define REF_NONE 2'h0
`define REF_SUPPLY 2'h1
`define REF_3V 2'h2
`define REF_5V 2'h3

// Code extremes
`define CODE_ZERO 14'h0000
`define CODE_FULL 14'h3FFF

// Status bit positions
`define ST_FORCE_LOW 0
`define ST_FORCE_HIGH 1
`define ST_CLIP 2
`define ST_WIDTH 3

`endif

/* logic/analog_output_code_gen.v */
// Analog output code generator with APB register slave
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "analog_output_defs.vh"

module analog_output_code_gen #(
  parameter DATA_W = 25,
  parameter CODE_W = 14
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Measurement results
  input wire [DATA_W-1:0] pressureCorrected,
  input wire [DATA_W-1:0] temp_one_corrected,
  input wire [DATA_W-1:0] temp_two_corrected,
  input wire [CODE_W-1:0] pressureRaw,
  input wire [CODE_W-1:0] tempOneRaw,
  input wire [CODE_W-1:0] tempTwoRaw,
  // Diagnostic flags
  input wire sensorError,
  input wire adcError,
  input wire crcRegError,
  input wire calcError,
  input wire lowThreshold,
  input wire highThreshold,
  // Start-up qualification
  input wire restartEvent,
  input wire configValid,
  input wire threePinModule,
  // Converter side
  output reg [CODE_W-1:0] dacCode,
  output reg [1:0] refSelect,
  output reg dacEnable,
  output reg loopMode,
  output reg analog_pinOnData,
  output reg analogActive,
  output reg irq
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Upper clip table, 100% down to 65%
  function [13:0] clipHigh;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: clipHigh = 14'h3FFF;
        3'h1: clipHigh = 14'h3CCC;
        3'h2: clipHigh = 14'h3999;
        3'h3: clipHigh = 14'h3666;
        3'h4: clipHigh = 14'h3332;
        3'h5: clipHigh = 14'h2FFF;
        3'h6: clipHigh = 14'h2CCC;
        default: clipHigh = 14'h2999;
      endcase
    end
  endfunction

  // Lower clip table, 0% up to 35%
  function [13:0] clipLow;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: clipLow = 14'h0000;
        3'h1: clipLow = 14'h0333;
        3'h2: clipLow = 14'h0666;
        3'h3: clipLow = 14'h0999;
        3'h4: clipLow = 14'h0CCD;
        3'h5: clipLow = 14'h1000;
        3'h6: clipLow = 14'h1333;
        default: clipLow = 14'h1666;
      endcase
    end
  endfunction

  // Address match on the exact byte offset, low address bits included
  function isAddr;
    input [11:0] a;
    input [11:0] off;
    begin
      isAddr = (a == off);
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  reg [31:0] ctrl_reg;
  reg [`ST_WIDTH-1:0] stat_reg;
  reg [`ST_WIDTH-1:0] mask_reg;
  reg active_reg;
  reg [CODE_W-1:0] code_next;
  reg [1:0] ref_next;
  reg forceLow;
  reg forceHigh;
  reg clipHit;
  reg [CODE_W-1:0] picked;
  reg [CODE_W-1:0] upper;
  reg [CODE_W-1:0] lower;
  reg [CODE_W-1:0] clipped;
  reg [31:0] rdata_next;
  reg [CODE_W-1:0] pressPick;
  reg [CODE_W-1:0] tempOnePick;
  reg [CODE_W-1:0] tempTwoPick;
  reg clipSeen;
  reg lowFault;
  reg highFault;

  wire [2:0] mode = ctrl_reg[`CTRL_MODE_LSB +: 3];
  wire tSel = ctrl_reg[`CTRL_TSEL_BIT];
  wire tPick = ctrl_reg[`CTRL_TPICK_BIT];
  wire pRawSel = ctrl_reg[`CTRL_PRAW_BIT];
  wire temp_one_unprocessed_sel = ctrl_reg[`CTRL_T1RAW_BIT];
  wire temp_two_unprocessed_sel = ctrl_reg[`CTRL_T2RAW_BIT];
  wire [2:0] clipHSel = ctrl_reg[`CTRL_CLIPH_LSB +: 3];
  wire [2:0] clipLSel = ctrl_reg[`CTRL_CLIPL_LSB +: 3];
  wire diagEnable = ctrl_reg[`CTRL_DIAG_BIT];
  wire modeOn = (mode == `MODE_RATIO) || (mode == `MODE_ABS3) ||
                (mode == `MODE_ABS5) || (mode == `MODE_LOOP);
  wire access = psel && penable;
  wire wrEn = access && pwrite;
  wire rdEn = access && !pwrite;
  wire [`ST_WIDTH-1:0] events = {clipHit, forceHigh, forceLow};

  // Mode groups used by the converter outputs
  wire loopSel = (mode == `MODE_LOOP);
  wire shareSel = (mode == `MODE_RATIO) || (mode == `MODE_ABS3) ||
                  (mode == `MODE_ABS5);

  // ----------------------------------------------------------------
  // Code path
  // ----------------------------------------------------------------

  // Pressure source, raw counts or corrected MSBs
  always @* begin
    if (pRawSel) begin
      pressPick = pressureRaw;
    end else begin
      pressPick = pressureCorrected[24:11];
    end
  end

  // Temperature one source
  always @* begin
    if (temp_one_unprocessed_sel) begin
      tempOnePick = tempOneRaw;
    end else begin
      tempOnePick = temp_one_corrected[24:11];
    end
  end

  // Temperature two source
  always @* begin
    if (temp_two_unprocessed_sel) begin
      tempTwoPick = tempTwoRaw;
    end else begin
      tempTwoPick = temp_two_corrected[24:11];
    end
  end

  // Channel pick, pressure or one of two temperatures
  always @* begin
    if (!tSel) begin
      picked = pressPick;
    end else if (!tPick) begin
      picked = tempOnePick;
    end else begin
      picked = tempTwoPick;
    end
  end

  // Lower then upper clip, no flag bits ever inserted
  always @* begin
    upper = clipHigh(clipHSel);
    lower = clipLow(clipLSel);
    clipSeen = 1'b0;
    clipped = picked;
    if (picked < lower) begin
      clipped = lower;
      clipSeen = 1'b1;
    end
    if (clipped > upper) begin
      clipped = upper;
      clipSeen = 1'b1;
    end
  end

  // Fault priority, sensor error first, high threshold last
  always @* begin
    lowFault = 1'b0;
    highFault = 1'b0;
    if (diagEnable) begin
      if (sensorError) begin
        lowFault = 1'b1;
      end else if (adcError) begin
        lowFault = 1'b1;
      end else if (crcRegError) begin
        lowFault = 1'b1;
      end else if (calcError) begin
        highFault = 1'b1;
      end else if (lowThreshold) begin
        lowFault = 1'b1;
      end else if (highThreshold) begin
        highFault = 1'b1;
      end
    end
  end

  // Final code, converter off wins, then forcing over clipping
  always @* begin
    forceLow = 1'b0;
    forceHigh = 1'b0;
    clipHit = 1'b0;
    code_next = clipped;
    if (!modeOn || !active_reg) begin
      code_next = `CODE_ZERO;
    end else begin
      clipHit = clipSeen;
      if (lowFault) begin
        code_next = `CODE_ZERO;
        forceLow = 1'b1;
      end else if (highFault) begin
        code_next = `CODE_FULL;
        forceHigh = 1'b1;
      end
    end
  end

  // Reference follows the mode field
  always @* begin
    case (mode)
      `MODE_RATIO: ref_next = `REF_SUPPLY;
      `MODE_ABS3: ref_next = `REF_3V;
      `MODE_ABS5: ref_next = `REF_5V;
      `MODE_LOOP: ref_next = `REF_SUPPLY;
      default: ref_next = `REF_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------

  // Read data selection
  always @* begin
    rdata_next = 32'h0000_0000;
    if (isAddr(paddr, `AO_CTRL_OFF)) begin
      rdata_next = ctrl_reg;
    end else if (isAddr(paddr, `AO_STAT_OFF)) begin
      rdata_next = {29'h0000_0000, stat_reg};
    end else if (isAddr(paddr, `AO_MASK_OFF)) begin
      rdata_next = {29'h0000_0000, mask_reg};
    end else if (isAddr(paddr, `AO_CODE_OFF)) begin
      rdata_next = {18'h0_0000, dacCode};
    end else if (isAddr(paddr, `AO_MODE_OFF)) begin
      rdata_next = {29'h0000_0000, analog_pinOnData, active_reg,
                    dacEnable};
    end
  end

  wire mapped = isAddr(paddr, `AO_CTRL_OFF) ||
                isAddr(paddr, `AO_STAT_OFF) ||
                isAddr(paddr, `AO_MASK_OFF) ||
                isAddr(paddr, `AO_CODE_OFF) ||
                isAddr(paddr, `AO_MODE_OFF);

  // Status bits handed out by the read, only these clear
  wire [`ST_WIDTH-1:0] readBits = prdata[`ST_WIDTH-1:0];

  // ----------------------------------------------------------------
  // Sequential logic
  // ----------------------------------------------------------------

  // APB slave, one wait-free access phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `CTRL_RESET_VAL;
      mask_reg <= {`ST_WIDTH{1'b0}};
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !pready;
      pslverr <= psel && !pready && !mapped;
      prdata <= (psel && !pwrite) ? rdata_next : 32'h0000_0000;
      if (wrEn && pready && isAddr(paddr, `AO_CTRL_OFF)) begin
        ctrl_reg <= pwdata;
      end
      if (wrEn && pready && isAddr(paddr, `AO_MASK_OFF)) begin
        mask_reg <= pwdata[`ST_WIDTH-1:0];
      end
    end
  end

  // Sticky status, read clears, new event wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= {`ST_WIDTH{1'b0}};
    end else if (rdEn && pready && isAddr(paddr, `AO_STAT_OFF)) begin
      stat_reg <= (stat_reg & ~readBits) | events;
    end else begin
      stat_reg <= stat_reg | events;
    end
  end

  // Analog mode entry on restart with valid config
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
    end else if (restartEvent) begin
      active_reg <= configValid;
    end
  end

  // Converter outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dacCode <= `CODE_ZERO;
      refSelect <= `REF_NONE;
      dacEnable <= 1'b0;
      loopMode <= 1'b0;
      analog_pinOnData <= 1'b0;
      analogActive <= 1'b0;
    end else begin
      dacCode <= code_next;
      refSelect <= ref_next;
      dacEnable <= modeOn && active_reg;
      loopMode <= loopSel && active_reg;
      // Same pin sharing in ratiometric and absolute modes
      analog_pinOnData <= active_reg && threePinModule && shareSel;
      analogActive <= active_reg;
    end
  end

  // Interrupt level from unmasked sticky status
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_reg & mask_reg);
    end
  end

endmodule // analog_output_code_gen

`default_nettype wire

/* dv/analog_output_code_gen_props.sv */
// Port assertions for the analog output code generator
`timescale 1ns/1ps
`default_nettype none
`include "analog_output_defs.vh"

module analog_output_code_gen_props #(
  parameter CODE_W = 14
) (
  // Clock, reset and bus
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // Start-up
  input wire restartEvent,
  input wire configValid,
  // Converter side
  input wire [CODE_W-1:0] dacCode,
  input wire [1:0] refSelect,
  input wire dacEnable,
  input wire loopMode,
  input wire analog_pinOnData,
  input wire analogActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Bus and converter relations
  // ----------------------------------------
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bad ready");
  property p_slverr;
    pready && (paddr > `AO_MODE_OFF || paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("no slverr");
  property p_idle;
    !analogActive |-> dacCode == `CODE_ZERO;
  endproperty
  a_idle: assert property (p_idle) else $error("code while idle");
  property p_off;
    !dacEnable && $past(dacEnable) == 1'b0 |-> dacCode == `CODE_ZERO;
  endproperty
  a_off: assert property (p_off) else $error("code while off");
  property p_loop;
    loopMode |-> dacEnable && refSelect == `REF_SUPPLY;
  endproperty
  a_loop: assert property (p_loop) else $error("loop ref");
  property p_ref;
    dacEnable && !loopMode |-> refSelect != `REF_NONE;
  endproperty
  a_ref: assert property (p_ref) else $error("no ref");
  property p_pin;
    analog_pinOnData |-> analogActive;
  endproperty
  a_pin: assert property (p_pin) else $error("pin shared early");
  property p_start;
    $rose(analogActive) |-> $past(restartEvent, 2) && $past(configValid, 2);
  endproperty
  a_start: assert property (p_start) else $error("bad start");
endmodule // analog_output_code_gen_props
`default_nettype wire

/* dv/analog_output_code_gen_tb_top.sv */
// Self-checking bench for the analog output code generator
`timescale 1ns/1ps
`default_nettype none
`include "analog_output_defs.vh"

module analog_output_code_gen_tb_top;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, act = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, ctrl;
  logic [24:0] pressC = 0, oneC = 0, twoC = 0;
  logic [13:0] pressR = 0, oneR = 0, twoR = 0;
  logic sErr = 0, aErr = 0, crcE = 0, calcE = 0, lowT = 0, highT = 0;
  logic rEv = 0, cfgOk = 0, three = 1;
  wire [31:0] prdata;
  wire [13:0] dacCode;
  wire [1:0] refSelect;
  wire pready, pslverr, dacEnable, loopMode, onData, analogActive, irq;
  int num_errors = 0, comparisons = 0, cycles = 0;
  integer seed = 32'hE4F4AF10;
  logic [13:0] hiTab [8] = '{14'h3FFF, 14'h3CCC, 14'h3999, 14'h3666,
    14'h3332, 14'h2FFF, 14'h2CCC, 14'h2999};
  logic [13:0] loTab [8] = '{14'h0000, 14'h0333, 14'h0666, 14'h0999,
    14'h0CCD, 14'h1000, 14'h1333, 14'h1666};
  logic [2:0] modes [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  logic [1:0] refs [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h0};

  analog_output_code_gen DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pressureCorrected(pressC), .temp_one_corrected(oneC),
    .temp_two_corrected(twoC), .pressureRaw(pressR), .tempOneRaw(oneR),
    .tempTwoRaw(twoR), .sensorError(sErr), .adcError(aErr),
    .crcRegError(crcE), .calcError(calcE), .lowThreshold(lowT),
    .highThreshold(highT), .restartEvent(rEv), .configValid(cfgOk),
    .threePinModule(three), .dacCode(dacCode), .refSelect(refSelect),
    .dacEnable(dacEnable), .loopMode(loopMode), .analog_pinOnData(onData),
    .analogActive(analogActive), .irq(irq));

  // Clock and timeout
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic flags(input logic [5:0] f);
    @(posedge clk);
    {sErr, aErr, crcE, calcE, lowT, highT} <= f;
  endtask
  task automatic restart(input logic ok);
    @(posedge clk);
    rEv <= 1;
    cfgOk <= ok;
    @(posedge clk);
    rEv <= 0;
    settle();
  endtask
  // Expected code: select, clip, then forcing
  function automatic logic [13:0] model(input logic [31:0] c);
    logic [13:0] v;
    if (!act || !c[2]) return 14'h0000;
    if (!c[3]) v = c[5] ? pressR : pressC[24:11];
    else if (!c[4]) v = c[6] ? oneR : oneC[24:11];
    else v = c[7] ? twoR : twoC[24:11];
    if (v < loTab[c[13:11]]) v = loTab[c[13:11]];
    if (v > hiTab[c[10:8]]) v = hiTab[c[10:8]];
    if (c[14]) begin
      if (sErr | aErr | crcE) v = 14'h0000;
      else if (calcE) v = 14'h3FFF;
      else if (lowT) v = 14'h0000;
      else if (highT) v = 14'h3FFF;
    end
    return v;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    apb(0, `AO_CTRL_OFF, 0);
    check("ctrl", rd, 0);
    apb(0, 12'h020, 0);
    check("slverr", e, 1);
    check("unmapped", rd, 0);
    apb(1, `AO_CTRL_OFF, 32'h4);
    restart(0);
    check("idle", dacCode, 0);
    check("active", analogActive, 0);
    restart(1);
    act = 1;
    $display("test start done");
    flags(6'h04);
    foreach (modes[i]) begin
      apb(1, `AO_CTRL_OFF, {17'h0, 15'h4000 | modes[i]});
      settle();
      check("ref", refSelect, refs[i]);
      check("loop", loopMode, modes[i] == 3'h7);
      check("code", dacCode, model(15'h4000 | modes[i]));
      check("enable", dacEnable, i < 4);
      check("pin", onData, i < 3);
    end
    $display("test modes done");
    repeat (60) begin
      ctrl = $random(seed) & 32'h7FF8 | (32'h4 + ($random(seed) & 3));
      apb(1, `AO_CTRL_OFF, ctrl);
      @(posedge clk);
      pressC <= 25'($random(seed));
      oneC <= 25'($random(seed));
      twoC <= 25'($random(seed));
      pressR <= 14'($random(seed));
      oneR <= 14'($random(seed));
      twoR <= 14'($random(seed));
      flags(6'($random(seed) & $random(seed) & $random(seed)));
      settle();
      check("code", dacCode, model(ctrl));
      apb(0, `AO_CODE_OFF, 0);
      check("codereg", rd, model(ctrl));
    end
    $display("test codes done");
    apb(1, `AO_MASK_OFF, 0);
    apb(1, `AO_CTRL_OFF, 32'h4004);
    flags(6'h20);
    flags(6'h00);
    settle();
    check("masked", irq, 0);
    apb(1, `AO_MASK_OFF, 1);
    flags(6'h20);
    flags(6'h00);
    settle();
    check("irq", irq, 1);
    apb(0, `AO_STAT_OFF, 0);
    check("stat", rd[0], 1);
    settle();
    check("cleared", irq, 0);
    $display("test interrupt done");
    test_done();
  end
endmodule // analog_output_code_gen_tb_top

bind analog_output_code_gen analog_output_code_gen_props #(.CODE_W(CODE_W))
  props (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .restartEvent(restartEvent), .configValid(configValid),
  .dacCode(dacCode), .refSelect(refSelect), .dacEnable(dacEnable),
  .loopMode(loopMode), .analog_pinOnData(analog_pinOnData),
  .analogActive(analogActive));
`default_nettype wire
